// ---- design/rsq_pkg.sv ----
package rsq_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [7:0] CTRL_ADDR = 8'h17;   // clock_output_and_interval_control
    localparam logic [7:0] STAT_ADDR = 8'h19;   // event_status_one
    localparam logic [7:0] MASK_ADDR = 8'h21;   // event_status_one_mask
    localparam logic [7:0] TRIM_ADDR = 8'hDA;   // frequency_trim

    // reset values
    localparam logic [15:0] CTRL_RESET = 16'h0020;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] TRIM_RESET = 16'h0000;

    // writable bits of each register
    localparam logic [15:0] CTRL_BITS = 16'h007F;
    localparam logic [15:0] MASK_BITS = 16'h00E0;
    localparam logic [15:0] TRIM_BITS = 16'h03FF;

    // field positions
    localparam int SQW_LSB    = 0;
    localparam int SQW_W      = 4;
    localparam int PINT_LSB   = 4;
    localparam int PINT_W     = 3;
    localparam int FLAG_LSB   = 5;
    localparam int FLAG_W     = 3;
    localparam int TRIM_W     = 10;
    localparam int TRIM_FRAC_W = 6;
    localparam int TRIM_INT_W = 4;

    // timing: one second of the 32 kHz oscillator
    localparam int          OSC_HZ        = 32768;
    localparam logic [14:0] SEC_CNT_LAST  = 15'h7FFF;
    localparam logic [3:0]  SQW_IDX_TOP   = 4'hF;

    // periodic interval select codes
    typedef enum logic [2:0] {
        PINT_OFF   = 3'h0,
        PINT_SEC   = 3'h1,
        PINT_MIN   = 3'h2,
        PINT_HOUR  = 3'h3,
        PINT_DAY   = 3'h4,
        PINT_MONTH = 3'h5
    } rsq_pint_type;

    // one register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rsq_bus_req_type;

    // event flags in status bit order 7:5
    typedef struct packed {
        logic periodic;
        logic seconds;
        logic alarm;
    } rsq_events_type;

endpackage : rsq_pkg

// ---- design/rsq_event_flag.sv ----
`timescale 1ns/1ps

// sticky flag set on a rising source edge, cleared by a read
module rsq_event_flag
    import rsq_pkg::*;
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic source,
    input  wire logic clear,
    output logic      flag
);

    logic prev;
    logic next_prev;
    logic next_flag;
    logic rise;

    // edge detect and sticky bit
    always_comb begin
        rise      = source && !prev;
        next_prev = source;
        next_flag = flag;
        if (clear) begin
            next_flag = 1'b0;
        end
        if (rise) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prev <= 1'b0;
            flag <= 1'b0;
        end else begin
            prev <= next_prev;
            flag <= next_flag;
        end
    end

    flag_set_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(source) |=> flag)
        else $error("flag missed a rising source edge");

    flag_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
        (clear && !$rose(source)) |=> !flag)
        else $error("flag survived a read");

endmodule : rsq_event_flag

// ---- design/rsq_rtc_events.sv ----
`timescale 1ns/1ps

module rsq_rtc_events
    import rsq_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            resetn,
    input  wire rsq_bus_req_type bus,
    output logic [15:0]          rd_data,
    input  wire logic            osc_tick,
    input  wire logic            minute_roll,
    input  wire logic            hour_roll,
    input  wire logic            day_roll,
    input  wire logic            month_roll,
    input  wire logic            alarm_match,
    input  wire logic            time_set_status,
    input  wire logic            pin_six_clock_out,
    output logic                 square_wave,
    output logic                 periodic_pulse,
    output logic                 clock_interrupt
);

    // register state
    logic [15:0]    ctrl;
    logic [15:0]    mask;
    logic [15:0]    trim;
    logic [15:0]    next_ctrl;
    logic [15:0]    next_mask;
    logic [15:0]    next_trim;
    logic [15:0]    next_rd_data;
    logic           stat_read;

    // tick generator state
    logic [14:0]       sec_cnt;
    logic [3:0]        hold_cnt;
    logic [5:0]        frac_acc;
    logic signed [4:0] adj;
    logic [14:0]       next_sec_cnt;
    logic [3:0]        next_hold_cnt;
    logic [5:0]        next_frac_acc;
    logic signed [4:0] next_adj;
    logic [3:0]        hold_limit;
    logic [6:0]        frac_sum;
    logic              sec_roll;

    // event and output state
    logic           sec_level;
    logic           next_sec_level;
    logic           next_periodic_pulse;
    logic           next_square_wave;
    logic           per_event;
    logic [3:0]     sqw_sel;
    logic [3:0]     sqw_idx;
    logic [15:0]    cnt_ext;
    rsq_pint_type   pint_sel;
    rsq_events_type flags;
    rsq_events_type sources;

    assign sqw_sel  = ctrl[SQW_LSB +: SQW_W];
    assign pint_sel = rsq_pint_type'(ctrl[PINT_LSB +: PINT_W]);

    // register port: writes and delayed read data
    always_comb begin
        next_ctrl    = ctrl;
        next_mask    = mask;
        next_trim    = trim;
        next_rd_data = 16'h0000;
        stat_read    = 1'b0;
        if (bus.wr) begin
            if (bus.addr == CTRL_ADDR) begin
                next_ctrl = bus.wdata & CTRL_BITS;
            end else if (bus.addr == MASK_ADDR) begin
                next_mask = bus.wdata & MASK_BITS;
            end else if (bus.addr == TRIM_ADDR) begin
                next_trim = bus.wdata & TRIM_BITS;
            end
        end
        if (bus.rd) begin
            if (bus.addr == CTRL_ADDR) begin
                next_rd_data = ctrl;
            end else if (bus.addr == STAT_ADDR) begin
                next_rd_data = {8'h00, flags, 5'h00};
                stat_read    = 1'b1;
            end else if (bus.addr == MASK_ADDR) begin
                next_rd_data = mask;
            end else if (bus.addr == TRIM_ADDR) begin
                next_rd_data = trim;
            end
        end
    end

    // select resets off, interval resets to minute, unmasked
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl    <= CTRL_RESET;
            mask    <= MASK_RESET;
            trim    <= TRIM_RESET;
            rd_data <= 16'h0000;
        end else begin
            ctrl    <= next_ctrl;
            mask    <= next_mask;
            trim    <= next_trim;
            rd_data <= next_rd_data;
        end
    end

    // tick generator: a second spans 32768 + adj oscillator ticks
    always_comb begin
        hold_limit    = adj[4] ? 4'h0 : adj[3:0];
        sec_roll      = osc_tick && (sec_cnt == SEC_CNT_LAST) && (hold_cnt == hold_limit);
        // fraction accumulates, carry adds one tick
        frac_sum      = {1'b0, frac_acc} + {1'b0, trim[TRIM_FRAC_W-1:0]};
        next_frac_acc = frac_acc;
        next_adj      = adj;
        next_sec_cnt  = sec_cnt;
        next_hold_cnt = hold_cnt;
        if (sec_roll) begin
            next_frac_acc = frac_sum[5:0];
            next_adj      = {trim[TRIM_W-1], trim[TRIM_W-1 -: TRIM_INT_W]} + {4'h0, frac_sum[6]};
            next_hold_cnt = 4'h0;
            // slow crystal skips ticks at the start of the high phase
            next_sec_cnt  = next_adj[4] ? {11'h000, 4'(-next_adj)} : 15'h0000;
        end else if (osc_tick) begin
            if (sec_cnt != SEC_CNT_LAST) begin
                next_sec_cnt = sec_cnt + 15'h0001;
            end else begin
                // fast crystal stretches the final low phase
                next_hold_cnt = hold_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sec_cnt  <= 15'h0000;
            hold_cnt <= 4'h0;
            frac_acc <= 6'h00;
            adj      <= 5'h00;
        end else begin
            sec_cnt  <= next_sec_cnt;
            hold_cnt <= next_hold_cnt;
            frac_acc <= next_frac_acc;
            adj      <= next_adj;
        end
    end

    // square wave from one bit of the second counter
    always_comb begin
        cnt_ext = {1'b0, sec_cnt};
        sqw_idx = SQW_IDX_TOP - sqw_sel;
        // bit 14 gives 1 Hz, bit 0 gives 16384 Hz
        // duty skew comes only from the trimmed counter
        next_square_wave = !cnt_ext[sqw_idx];
        if (sqw_sel == 4'h0) begin
            next_square_wave = 1'b0;
        end
        // only when pin six carries the clock
        if (!pin_six_clock_out) begin
            next_square_wave = 1'b0;
        end
    end

    // periodic source select and pulse stretching
    always_comb begin
        case (pint_sel)
            PINT_SEC:   per_event = sec_roll;
            PINT_MIN:   per_event = minute_roll;
            PINT_HOUR:  per_event = hour_roll;
            PINT_DAY:   per_event = day_roll;
            PINT_MONTH: per_event = month_roll;
            default:    per_event = 1'b0;
        endcase
        // pulse held until the next oscillator tick
        next_periodic_pulse = periodic_pulse;
        if (osc_tick) begin
            next_periodic_pulse = 1'b0;
        end
        if (per_event) begin
            next_periodic_pulse = 1'b1;
        end
        // nothing while time is being set
        if (time_set_status) begin
            next_periodic_pulse = 1'b0;
        end
        // seconds level also lasts one oscillator period
        next_sec_level = sec_roll || (sec_level && !osc_tick);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            square_wave    <= 1'b0;
            periodic_pulse <= 1'b0;
            sec_level      <= 1'b0;
        end else begin
            square_wave    <= next_square_wave;
            periodic_pulse <= next_periodic_pulse;
            sec_level      <= next_sec_level;
        end
    end

    // event sources for the three flags
    assign sources.periodic = periodic_pulse;
    assign sources.seconds  = sec_level;
    assign sources.alarm    = alarm_match;

    genvar gi;
    generate
        for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
            rsq_event_flag u_flag (
                .mclk   (mclk),
                .resetn (resetn),
                .source (sources[gi]),
                .clear  (stat_read),
                .flag   (flags[gi])
            );
        end
    endgenerate

    // one level interrupt from unmasked flags
    assign clock_interrupt = |(flags & ~mask[FLAG_LSB +: FLAG_W]);

    // helper: oscillator ticks since the last rollover
    logic [16:0] tick_count;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick_count <= 17'h00000;
        end else if (sec_roll) begin
            tick_count <= 17'h00000;
        end else if (osc_tick) begin
            tick_count <= tick_count + 17'h00001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence seconds_source_s;
        sec_roll ##1 sec_level;
    endsequence

    sequence seconds_flag_s;
        ##1 flags.seconds;
    endsequence

    sqw_off_a: assert property (
        (sqw_sel == 4'h0) |=> !square_wave)
        else $error("square wave active with select zero");

    sqw_pin_a: assert property (
        !pin_six_clock_out |=> !square_wave)
        else $error("square wave active without pin six clock function");

    sec_length_a: assert property (
        sec_roll |-> (int'(tick_count) + 1 == OSC_HZ + int'(adj)))
        else $error("second length does not match trim");

    hold_low_a: assert property (
        (hold_cnt != 4'h0) |=> !square_wave)
        else $error("trim stretch did not hold the wave low");

    skew_range_a: assert property (
        (adj >= -5'sd8) && (adj <= 5'sd8))
        else $error("trim adjustment beyond eight ticks");

    per_hold_a: assert property (
        (periodic_pulse && !osc_tick && !time_set_status) |=> periodic_pulse)
        else $error("periodic pulse ended before the oscillator tick");

    per_end_a: assert property (
        (periodic_pulse && osc_tick && !per_event) |=> !periodic_pulse)
        else $error("periodic pulse outlived one oscillator period");

    per_block_a: assert property (
        time_set_status |=> !periodic_pulse)
        else $error("periodic pulse while time set status high");

    per_minute_a: assert property (
        (pint_sel == PINT_MIN && minute_roll && !time_set_status) |=> periodic_pulse)
        else $error("minute interval produced no pulse");

    sec_flag_a: assert property (
        seconds_source_s |-> seconds_flag_s)
        else $error("seconds rollover did not set the seconds flag");

    alarm_irq_a: assert property (
        ($rose(alarm_match) && !mask[FLAG_LSB] && !bus.wr) |=> clock_interrupt)
        else $error("alarm match did not raise the clock interrupt");

    mask_all_a: assert property (
        (mask[FLAG_LSB +: FLAG_W] == 3'h7) |-> !clock_interrupt)
        else $error("interrupt raised with all flags masked");

endmodule : rsq_rtc_events

// ---- tb/rsq_host_model.sv ----
`timescale 1ns/1ps

// host side of the register port: one-cycle strobes, changed right after an edge
module rsq_host_model
    import rsq_pkg::*;
(
    input  wire logic       mclk,
    output rsq_bus_req_type bus
);
    // idle port starts at zero; after each strobe it scrambles address and data so nothing stale looks valid
    initial bus = '{addr: 8'h00, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 16'hA5C3, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '{addr: ~a, wdata: 16'h5A3C, wr: 1'b0, rd: 1'b0};
    endtask : rd
endmodule : rsq_host_model

// ---- tb/rsq_rtc_events_tb.sv ----
`timescale 1ns/1ps

module rsq_rtc_events_tb;
    import rsq_pkg::*;
    logic            mclk = 0, resetn = 0, osc_tick = 0, alarm = 0, tset = 0, pin6 = 1;
    logic [3:0]      roll = 4'h0;   // minute, hour, day, month
    logic            sqw, ppulse, cint, rd_seen = 0, fast = 0;
    rsq_bus_req_type bus;
    logic [15:0]     rd_data;
    logic [15:0]     exp_q[$];
    int              n_fail = 0, n_checks = 0, tick_cnt = 0, t1 = 0;
    logic [7:0]      addrs [5] = '{CTRL_ADDR, MASK_ADDR, TRIM_ADDR, STAT_ADDR, 8'h55};
    logic [15:0]     keep  [5] = '{CTRL_BITS, MASK_BITS, TRIM_BITS, 16'h0000, 16'h0000};
    logic [15:0]     rstv  [5] = '{CTRL_RESET, MASK_RESET, TRIM_RESET, 16'h0000, 16'h0000};

    always #4 mclk = ~mclk;

    rsq_host_model host (.mclk(mclk), .bus(bus));

    rsq_rtc_events DUT (.mclk(mclk), .resetn(resetn), .bus(bus), .rd_data(rd_data), .osc_tick(osc_tick),
        .minute_roll(roll[0]), .hour_roll(roll[1]), .day_roll(roll[2]), .month_roll(roll[3]),
        .alarm_match(alarm), .time_set_status(tset), .pin_six_clock_out(pin6), .square_wave(sqw),
        .periodic_pulse(ppulse), .clock_interrupt(cint));

    task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_pin(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_pin

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // note the expectation, then issue the read
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask : rd

    // step past edges so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // read data appears only in the cycle after a read strobe; looked at mid-cycle, where it has settled
    always @(negedge mclk) begin
        if (rd_seen)
            cmp_rd(rd_data, exp_q.pop_front()); // read result
        else
            cmp_rd(rd_data, 16'h0000); // idle data low
        rd_seen <= bus.rd;
    end

    // oscillator enable every other cycle, every cycle in fast mode so two seconds fit the run
    always @(posedge mclk) begin
        osc_tick <= resetn & (fast | ~osc_tick);
        if (osc_tick)
            tick_cnt++;
    end

    initial begin
        int n;
        int e;
        logic [15:0] d;
        logic [2:0] code;
        logic [3:0] sel;
        logic hit;
        logic s;
        n = $urandom(8578);
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        rd(CTRL_ADDR, CTRL_RESET); // select resets
        rd(MASK_ADDR, MASK_RESET); // reset unmasked
        rd(TRIM_ADDR, TRIM_RESET); // trim resets
        rd(STAT_ADDR, 16'h0000); // flags clear
        // random words: stored bits only, status and unmapped ignore writes
        for (int i = 0; i < 5; i++) begin
            d = 16'($urandom);
            host.wr(addrs[i], d);
            rd(addrs[i], d & keep[i]); // stored bits
            host.wr(addrs[i], rstv[i]);
        end
        // alarm flag, clear on read, masking
        @(posedge mclk) alarm <= 1'b1;
        tick(3);
        cmp_pin(cint, 1'b1); // alarm raises
        rd(STAT_ADDR, 16'h0020); // alarm bit
        tick(2);
        cmp_pin(cint, 1'b0); // read drops
        rd(STAT_ADDR, 16'h0000); // held level once
        host.wr(MASK_ADDR, 16'h00E0);
        @(posedge mclk) alarm <= 1'b0;
        @(posedge mclk) alarm <= 1'b1;
        tick(3);
        cmp_pin(cint, 1'b0); // masked flag
        host.wr(MASK_ADDR, 16'h0000);
        tick(1);
        cmp_pin(cint, 1'b1); // unmask shows
        rd(STAT_ADDR, 16'h0020); // kept under mask
        @(posedge mclk) alarm <= 1'b0;
        // every interval code against every roll source; last pass under time-set
        for (int c = 0; c < 9; c++) begin
            code = (c == 8) ? 3'h2 : c[2:0];
            host.wr(CTRL_ADDR, {9'h000, code, 4'h0});
            @(posedge mclk) tset <= (c == 8);
            for (int r = 0; r < 4; r++) begin
                hit = (c != 8) && (c == r + 2);
                @(posedge mclk) roll[r] <= 1'b1;
                @(posedge mclk) roll[r] <= 1'b0;
                #1;
                cmp_pin(ppulse, hit); // interval select
                tick(4);
                cmp_pin(ppulse, 1'b0); // one period
                rd(STAT_ADDR, {8'h00, hit, 7'h00}); // periodic bit
            end
        end
        @(posedge mclk) tset <= 1'b0;
        // toggle count doubles per code step; code 0 and pin off stay low
        for (int i = 0; i < 6; i++) begin
            sel = (i < 4) ? 4'(12 + i) : ((i == 4) ? 4'h0 : 4'hF);
            e = (i < 4) ? (128 >> (3 - i)) : 0;
            host.wr(CTRL_ADDR, {12'h000, sel});
            @(posedge mclk) pin6 <= (i != 5);
            tick(4);
            n = 0;
            repeat (256) begin
                s = sqw;
                tick(1);
                if (sqw !== s)
                    n++;
            end
            cmp_pin(e > 0 ? (n >= e - 1 && n <= e + 1) : (n == 0 && sqw === 1'b0), 1'b1); // rate
        end
        // trim +7 whole ticks, latched at the first rollover; 1 Hz wave on the pin, seconds interval
        host.wr(TRIM_ADDR, 16'h01C0);
        host.wr(CTRL_ADDR, 16'h0011);
        @(posedge mclk) pin6 <= 1'b1;
        fast <= 1'b1;
        // first rollover after 32768 ticks sets the seconds flag
        for (n = 0; n < 40000 && cint !== 1'b1; n++)
            tick(1);
        t1 = tick_cnt;
        if (n < 40000) begin
            cmp_pin(t1 >= 32768 && t1 <= 32770, 1'b1); // one second
            cmp_pin(sqw, 1'b1); // high after rollover
            rd(STAT_ADDR, 16'h00C0); // seconds and interval
            // let the read clear land before polling again
            tick(2);
            // next second lasts 32768 + 7 ticks, its last low phase stretched
            for (n = 0; n < 40000 && cint !== 1'b1; n++)
                tick(1);
            if (n < 40000) begin
                cmp_pin(tick_cnt - t1 == 32775, 1'b1); // trimmed length
                cmp_pin(sqw, 1'b1); // high after stretch
                rd(STAT_ADDR, 16'h00C0); // flags again
            end else begin
                // second rollover never came
                n_fail++;
            end
        end else begin
            // first rollover never came
            n_fail++;
        end
        tick(3);
        conclude();
    end
endmodule : rsq_rtc_events_tb
